// ---- logic/sbd_pkg.sv ----
// Purpose: Shared constants and carriers for the function BAR decoder.
// Assumes: 32-bit AHB-Lite register bus, word accesses only.
// Notes:   Offsets are byte addresses inside the register window.
package sbd_pkg;
    localparam int NUM_SLOTS = 6;
    localparam int NUM_VEC   = 8;
    localparam int SLOT_W    = 3;
    localparam int VEC_W     = 3;
    // Register map
    localparam logic [11:0] CTRL_OFS     = 12'h000;
    localparam logic [11:0] STAT_OFS     = 12'h004;
    localparam logic [11:0] CFG_OFS      = 12'h020;
    localparam logic [11:0] BASE_OFS     = 12'h040;
    localparam logic [11:0] TAB_OFS      = 12'h100;
    localparam logic [11:0] PBA_OFS      = 12'h180;
    // Control fields
    localparam int CTRL_DEV_LSB  = 0;
    localparam int CTRL_MSIX_LSB = 2;
    localparam int CTRL_FNMASK   = 4;
    localparam int CTRL_MSIX_EN  = 5;
    // Status fields
    localparam int STAT_ACT_LSB  = 0;
    localparam int STAT_ERR_LSB  = 8;
    localparam int STAT_LAST_LSB = 16;
    localparam int STAT_SEEN     = 19;
    // Slot config fields
    localparam int CFG_EN        = 0;
    localparam int CFG_IO        = 1;
    localparam int CFG_64        = 2;
    localparam int CFG_PF        = 3;
    localparam int CFG_SIZE_LSB  = 4;
    localparam int CFG_SIZE_W    = 6;
    // Window size limits as log2 of bytes
    localparam logic [5:0] MIN_STD_LOG2    = 6'h07;
    localparam logic [5:0] MIN_LEGACY_LOG2 = 6'h04;
    localparam logic [5:0] MAX_32_LOG2     = 6'h1f;
    localparam logic [5:0] MAX_64_LOG2     = 6'h3f;
    localparam int ROOT_SLOTS = 2;
    localparam logic [31:0] CFG_RESET = 32'h0000_0070;

    typedef enum logic [1:0] {
        DEV_ENDPOINT = 2'h0,
        DEV_LEGACY   = 2'h1,
        DEV_ROOT     = 2'h2
    } sbd_dev_type;

    typedef enum logic [1:0] {
        MSIX_NONE     = 2'h0,
        MSIX_EXTERNAL = 2'h1,
        MSIX_INTERNAL = 2'h2,
        MSIX_STREAM   = 2'h3
    } sbd_msix_type;

    typedef struct packed {
        logic                  en;
        logic                  io;
        logic                  is64;
        logic                  pf;
        logic [CFG_SIZE_W-1:0] sizeLog2;
    } sbd_cfg_type;

    typedef struct packed {
        logic        valid;
        logic        io;
        logic [63:0] addr;
    } sbd_req_type;

    typedef struct packed {
        logic              valid;
        logic              miss;
        logic [SLOT_W-1:0] slot;
        logic [63:0]       offset;
    } sbd_hit_type;

    typedef struct packed {
        logic             valid;
        logic [VEC_W-1:0] vec;
    } sbd_vreq_type;

    typedef struct packed {
        logic             valid;
        logic [VEC_W-1:0] vec;
        logic [63:0]      addr;
        logic [31:0]      data;
    } sbd_msg_type;
endpackage : sbd_pkg

// ---- logic/sbd_bar_decode.sv ----
// Purpose: BAR configuration, request decode and MSI-X storage option.
// Assumes: One AHB-Lite master, word transfers, requests on core_clk.
// Notes:   Decode result is registered one cycle after a request.
// Function
// - As an endpoint up to six 32-bit windows, or three 64-bit pairs.
// - As a root port only two 32-bit windows or one 64-bit window.
// - A 64-bit memory window takes the next slot for its upper address.
// - An I/O window is 32-bit, never prefetchable, legacy endpoint only.
// - A memory window may be 32-bit or 64-bit and may be prefetchable.
// - A window claims only requests of its own space, memory or I/O.
// - Standard endpoint sizes are 128 B to 2 GB or 128 B to 8 EB.
// - Legacy endpoint sizes start at 16 B with the same maxima.
// - Standard endpoint prefetchable windows but the last must be 64-bit.
// - Smallest window is 128 B standard and 16 B legacy.
// - Every slot has its own enable; unused slots stay disabled.
// - External MSI-X keeps the table and pending bits outside the block.
// - Internal MSI-X keeps the table and pending bits in this block.
`timescale 1ns/1ps
module sbd_bar_decode #(
    parameter int NUM_SLOTS = sbd_pkg::NUM_SLOTS,
    parameter int NUM_VEC   = sbd_pkg::NUM_VEC
) (
    input  wire logic                 core_clk,
    input  wire logic                 sys_rst,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic [31:0]               hrdata,
    output logic                      hresp,
    input  wire sbd_pkg::sbd_req_type  reqIn,
    output sbd_pkg::sbd_hit_type       hitOut,
    input  wire sbd_pkg::sbd_vreq_type vecReqIn,
    output sbd_pkg::sbd_msg_type       msgOut,
    output sbd_pkg::sbd_msix_type      msixModeOut
);
    import sbd_pkg::*;

    sbd_dev_type           devMode_q;
    sbd_msix_type          msixMode_q;
    logic                  fnMask_q;
    logic                  msixEn_q;
    sbd_cfg_type           cfg_q    [NUM_SLOTS];
    logic [31:0]           base_q   [NUM_SLOTS];
    logic [31:0]           tab_q    [NUM_VEC*4];
    logic [NUM_VEC-1:0]    pba_q;
    logic [NUM_SLOTS-1:0]  active;
    logic [NUM_SLOTS-1:0]  cfgErr;
    logic [NUM_SLOTS-1:0]  upper;
    logic [SLOT_W-1:0]     lastSlot_q;
    logic                  seen_q;
    logic                  wrPend_q;
    logic                  rdPend_q;
    logic                  rdDone_q;
    logic [11:0]           addr_q;
    logic [31:0]           hrdata_q;
    sbd_hit_type           hit_q;
    sbd_msg_type           msg_q;
    logic                  accept;
    logic                  internalMsix;

    assign accept       = hsel & htrans[1] & hready;
    assign internalMsix = (msixMode_q == MSIX_INTERNAL);
    // Reads take one wait state so a write just before is already stored
    assign hreadyout    = ~(rdPend_q & ~rdDone_q);
    assign hrdata       = hrdata_q;
    assign hresp        = 1'b0;
    assign hitOut       = hit_q;
    assign msgOut       = msg_q;
    assign msixModeOut  = msixMode_q;

    // Byte mask of the bits that lie inside a window
    function automatic logic [63:0] winMask(input logic [5:0] sz);
        winMask = (64'h1 << sz) - 64'h1;
    endfunction : winMask

    function automatic logic [63:0] fullBase(input int i);
        logic [31:0] hi;
        hi = 32'h0;
        if (cfg_q[i].is64 && i < NUM_SLOTS - 1) begin
            hi = base_q[i+1];
        end
        fullBase = {hi, base_q[i]};
    endfunction : fullBase

    function automatic int tabIdx(input logic [11:0] a);
        tabIdx = int'(a[7:2]);
    endfunction : tabIdx

    // Slot legality from the current device mode
    always_comb begin
        logic       legacy;
        logic       bad;
        logic [5:0] minSz;
        logic [5:0] maxSz;
        legacy = 1'b0;
        bad    = 1'b0;
        minSz  = MIN_STD_LOG2;
        maxSz  = MAX_32_LOG2;
        for (int i = 0; i < NUM_SLOTS; i++) begin
            legacy = (devMode_q == DEV_LEGACY);
            bad    = 1'b0;
            upper[i] = (i > 0) ? (cfg_q[i-1].en && !cfg_q[i-1].io
                                  && cfg_q[i-1].is64) : 1'b0;
            if (devMode_q == DEV_ROOT && i >= ROOT_SLOTS) begin
                bad = 1'b1;
            end
            if (devMode_q == DEV_ROOT && cfg_q[i].is64 && i != 0) begin
                bad = 1'b1;
            end
            if (cfg_q[i].is64 && i == NUM_SLOTS - 1) begin
                bad = 1'b1;
            end
            if (cfg_q[i].io && (!legacy || cfg_q[i].is64
                                || cfg_q[i].pf)) begin
                bad = 1'b1;
            end
            minSz = legacy ? MIN_LEGACY_LOG2 : MIN_STD_LOG2;
            maxSz = (cfg_q[i].is64 && !cfg_q[i].io) ? MAX_64_LOG2
                                                     : MAX_32_LOG2;
            if (cfg_q[i].sizeLog2 < minSz
                || cfg_q[i].sizeLog2 > maxSz) begin
                bad = 1'b1;
            end
            if (!legacy && cfg_q[i].pf && !cfg_q[i].io && !cfg_q[i].is64
                && i != NUM_SLOTS - 1) begin
                bad = 1'b1;
            end
            active[i] = cfg_q[i].en && !upper[i] && !bad;
            cfgErr[i] = cfg_q[i].en && !upper[i] && bad;
        end
    end

    // Request decode, lowest slot wins on overlap
    always_ff @(posedge core_clk or posedge sys_rst) begin
        logic        found;
        logic [63:0] m;
        if (sys_rst) begin
            hit_q      <= '0;
            lastSlot_q <= '0;
            seen_q     <= 1'b0;
        end else begin
            found = 1'b0;
            m     = 64'h0;
            hit_q <= '0;
            if (reqIn.valid) begin
                for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
                    m = winMask(cfg_q[i].sizeLog2);
                    if (active[i] && (reqIn.io == cfg_q[i].io)
                        && (cfg_q[i].is64 || reqIn.addr[63:32] == 32'h0)
                        && ((reqIn.addr & ~m) == (fullBase(i) & ~m))) begin
                        found         = 1'b1;
                        hit_q.slot   <= SLOT_W'(i);
                        hit_q.offset <= reqIn.addr & m;
                        lastSlot_q   <= SLOT_W'(i);
                    end
                end
                hit_q.valid <= found;
                hit_q.miss  <= ~found;
                if (found) begin
                    seen_q <= 1'b1;
                end
            end
        end
    end

    // Bus phases
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wrPend_q <= 1'b0;
            rdPend_q <= 1'b0;
            rdDone_q <= 1'b0;
            addr_q   <= '0;
        end else begin
            wrPend_q <= 1'b0;
            if (rdPend_q && !rdDone_q) begin
                rdDone_q <= 1'b1;
            end
            if (rdDone_q) begin
                rdPend_q <= 1'b0;
                rdDone_q <= 1'b0;
            end
            if (accept) begin
                addr_q   <= {haddr[11:2], 2'b00};
                wrPend_q <= hwrite;
                rdPend_q <= ~hwrite;
                rdDone_q <= 1'b0;
            end
        end
    end

    // Read data captured during the wait state
    always_ff @(posedge core_clk or posedge sys_rst) begin
        logic [31:0] r;
        int          s;
        logic [63:0] wm;
        if (sys_rst) begin
            hrdata_q <= '0;
        end else if (rdPend_q && !rdDone_q) begin
            r = 32'h0;
            s = 0;
            if (addr_q == CTRL_OFS) begin
                r[CTRL_DEV_LSB +: 2]  = devMode_q;
                r[CTRL_MSIX_LSB +: 2] = msixMode_q;
                r[CTRL_FNMASK]        = fnMask_q;
                r[CTRL_MSIX_EN]       = msixEn_q;
            end else if (addr_q == STAT_OFS) begin
                r[STAT_ACT_LSB +: NUM_SLOTS]  = active;
                r[STAT_ERR_LSB +: NUM_SLOTS]  = cfgErr;
                r[STAT_LAST_LSB +: SLOT_W]    = lastSlot_q;
                r[STAT_SEEN]                  = seen_q;
            end else if (addr_q >= CFG_OFS
                         && addr_q < CFG_OFS + 12'(4*NUM_SLOTS)) begin
                s = int'(addr_q[11:2] - CFG_OFS[11:2]);
                r[CFG_EN]                     = cfg_q[s].en;
                r[CFG_IO]                     = cfg_q[s].io;
                r[CFG_64]                     = cfg_q[s].is64;
                r[CFG_PF]                     = cfg_q[s].pf;
                r[CFG_SIZE_LSB +: CFG_SIZE_W] = cfg_q[s].sizeLog2;
            end else if (addr_q >= BASE_OFS
                         && addr_q < BASE_OFS + 12'(4*NUM_SLOTS)) begin
                s = int'(addr_q[11:2] - BASE_OFS[11:2]);
                if (upper[s]) begin
                    r = base_q[s];
                end else begin
                    // Size probing: bits inside the window read as zero, apart from the type bits 0, 2 and 3
                    wm = winMask(cfg_q[s].sizeLog2);
                    r = base_q[s] & ~wm[31:0];
                    r[0] = cfg_q[s].io;
                    r[2] = cfg_q[s].is64 & ~cfg_q[s].io;
                    r[3] = cfg_q[s].pf & ~cfg_q[s].io;
                end
            end else if (internalMsix && addr_q >= TAB_OFS
                         && addr_q < TAB_OFS + 12'(16*NUM_VEC)) begin
                r = tab_q[tabIdx(addr_q - TAB_OFS)];
            end else if (internalMsix && addr_q == PBA_OFS) begin
                r[NUM_VEC-1:0] = pba_q;
            end
            hrdata_q <= r;
        end
    end

    // Control register
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            devMode_q  <= DEV_ENDPOINT;
            msixMode_q <= MSIX_NONE;
            fnMask_q   <= 1'b0;
            msixEn_q   <= 1'b0;
        end else if (wrPend_q && addr_q == CTRL_OFS) begin
            devMode_q  <= (hwdata[CTRL_DEV_LSB +: 2] == 2'h3)
                          ? DEV_ENDPOINT
                          : sbd_dev_type'(hwdata[CTRL_DEV_LSB +: 2]);
            msixMode_q <= sbd_msix_type'(hwdata[CTRL_MSIX_LSB +: 2]);
            fnMask_q   <= hwdata[CTRL_FNMASK];
            msixEn_q   <= hwdata[CTRL_MSIX_EN];
        end
    end

    // Slot configuration and base words
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_SLOTS; i++) begin
                // Field by field: the struct packs en at its top bit
                cfg_q[i].en       <= CFG_RESET[CFG_EN];
                cfg_q[i].io       <= CFG_RESET[CFG_IO];
                cfg_q[i].is64     <= CFG_RESET[CFG_64];
                cfg_q[i].pf       <= CFG_RESET[CFG_PF];
                cfg_q[i].sizeLog2 <= CFG_RESET[CFG_SIZE_LSB +: CFG_SIZE_W];
                base_q[i] <= 32'h0;
            end
        end else if (wrPend_q) begin
            for (int i = 0; i < NUM_SLOTS; i++) begin
                if (addr_q == CFG_OFS + 12'(4*i)) begin
                    cfg_q[i].en       <= hwdata[CFG_EN];
                    cfg_q[i].io       <= hwdata[CFG_IO];
                    cfg_q[i].is64     <= hwdata[CFG_64];
                    cfg_q[i].pf       <= hwdata[CFG_PF];
                    cfg_q[i].sizeLog2 <= hwdata[CFG_SIZE_LSB +: CFG_SIZE_W];
                end
                if (addr_q == BASE_OFS + 12'(4*i)) begin
                    base_q[i] <= hwdata;
                end
            end
        end
    end

    // MSI-X table, only reachable in the internal option
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int v = 0; v < NUM_VEC*4; v++) begin
                tab_q[v] <= (v % 4 == 3) ? 32'h1 : 32'h0;
            end
        end else if (wrPend_q && internalMsix && addr_q >= TAB_OFS
                     && addr_q < TAB_OFS + 12'(16*NUM_VEC)) begin
            tab_q[tabIdx(addr_q - TAB_OFS)] <= hwdata;
        end
    end

    // Internal message issue and pending bits. A new request and a resend
    // are exclusive, so a set can never collide with a clear.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        logic        sent;
        int          vi;
        if (sys_rst) begin
            pba_q <= '0;
            msg_q <= '0;
        end else begin
            sent  = 1'b0;
            vi    = 0;
            msg_q.valid <= 1'b0;
            if (!internalMsix || !msixEn_q) begin
                // External, stream and none keep no state here
                pba_q <= '0;
            end else if (vecReqIn.valid) begin
                vi = int'(vecReqIn.vec);
                if (fnMask_q || tab_q[vi*4+3][0]) begin
                    pba_q[vi] <= 1'b1;
                end else begin
                    sent = 1'b1;
                end
            end else begin
                for (int v = NUM_VEC - 1; v >= 0; v--) begin
                    if (pba_q[v] && !tab_q[v*4+3][0] && !fnMask_q) begin
                        vi   = v;
                        sent = 1'b1;
                    end
                end
                if (sent) begin
                    pba_q[vi] <= 1'b0;
                end
            end
            if (sent) begin
                msg_q.valid <= 1'b1;
                msg_q.vec   <= VEC_W'(vi);
                msg_q.addr  <= {tab_q[vi*4+1], tab_q[vi*4]};
                msg_q.data  <= tab_q[vi*4+2];
            end
        end
    end
endmodule : sbd_bar_decode

// ---- tb/sbd_bar_decode_chk.sv ----
// Purpose: Port-level assertions for the function BAR decoder.
// Assumes: One core_clk domain, sys_rst asynchronous active high.
// Notes:   Bound to every sbd_bar_decode instance.
`timescale 1ns/1ps
module sbd_bar_decode_chk
    import sbd_pkg::*;
#(
    parameter int NUM_SLOTS = sbd_pkg::NUM_SLOTS
) (
    input wire logic                  core_clk,
    input wire logic                  sys_rst,
    input wire logic                  hsel,
    input wire logic [1:0]            htrans,
    input wire logic                  hwrite,
    input wire logic                  hready,
    input wire logic                  hreadyout,
    input wire logic                  hresp,
    input wire sbd_pkg::sbd_req_type  reqIn,
    input wire sbd_pkg::sbd_hit_type  hitOut,
    input wire sbd_pkg::sbd_msg_type  msgOut,
    input wire sbd_pkg::sbd_msix_type msixModeOut
);
    logic rdTaken;
    logic wrTaken;
    assign rdTaken = hsel && htrans[1] && hready && !hwrite;
    assign wrTaken = hsel && htrans[1] && hready && hwrite;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    AST_HRESP_OKAY: assert property (hresp == 1'b0)
        else $error("bus response not OKAY");
    AST_RD_WAIT: assert property (rdTaken |=> !hreadyout ##1 hreadyout)
        else $error("read wait state not exactly one cycle");
    AST_WR_NOWAIT: assert property (wrTaken |=> hreadyout)
        else $error("write data phase stalled");
    AST_HIT_NEXT: assert property (reqIn.valid |=> hitOut.valid != hitOut.miss)
        else $error("request not answered by one hit or miss");
    AST_HIT_IDLE: assert property (!reqIn.valid |=> !hitOut.valid && !hitOut.miss)
        else $error("decode answer without a request");
    AST_SLOT_RANGE: assert property (hitOut.valid |-> hitOut.slot < NUM_SLOTS)
        else $error("hit names a slot beyond the last");
    AST_MSG_INTERNAL: assert property (msgOut.valid |-> msixModeOut == MSIX_INTERNAL)
        else $error("message sent outside internal option");
    AST_MODE_BY_WRITE: assert property ($changed(msixModeOut) |-> $past(wrTaken, 2))
        else $error("option changed without a register write");

    COV_HIT: cover property (hitOut.valid);
    COV_MISS: cover property (hitOut.miss);
    COV_MSG: cover property (msgOut.valid);
endmodule : sbd_bar_decode_chk

bind sbd_bar_decode sbd_bar_decode_chk #(.NUM_SLOTS(NUM_SLOTS)) chk (
    .core_clk(core_clk), .sys_rst(sys_rst), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .reqIn(reqIn), .hitOut(hitOut), .msgOut(msgOut),
    .msixModeOut(msixModeOut)
);

// ---- tb/sbd_host_model.sv ----
// Purpose: Link-side requester issuing memory and I/O requests.
// Assumes: One request at a time, answer one cycle later.
// Notes:   Off-request the address shows its inverse, never the stale value.
`timescale 1ns/1ps
module sbd_host_model (
    input wire logic                 core_clk,
    output sbd_pkg::sbd_req_type     reqIn,
    input wire sbd_pkg::sbd_hit_type hitOut
);
    import sbd_pkg::*;
    initial reqIn = '0;
    // Whole requests only; any merging of byte writes happens before here
    task automatic issue(input logic io, input logic [63:0] a,
                         output sbd_hit_type h);
        @(posedge core_clk);
        reqIn <= '{valid: 1'b1, io: io, addr: a};
        @(posedge core_clk);
        reqIn <= '{valid: 1'b0, io: ~io, addr: ~a};
        #1 h = hitOut;
    endtask : issue
endmodule : sbd_host_model

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench for the function BAR decoder.
// Assumes: AHB-Lite single word transfers, one slave.
// Notes:   Slot configs build on each other; order of steps matters.
`timescale 1ns/1ps
module tb_top;
    import sbd_pkg::*;
    logic         core_clk, sys_rst, hsel, hwrite, hreadyout, hresp;
    logic [31:0]  haddr, hwdata, hrdata, d;
    logic [1:0]   htrans;
    logic [2:0]   hsize;
    wire          hready = hreadyout;
    sbd_req_type  reqIn;
    sbd_hit_type  hitOut;
    sbd_vreq_type vecReqIn;
    sbd_msg_type  msgOut, m;
    sbd_msix_type msixModeOut;
    int           miscompares, total_checks, cycles;

    sbd_bar_decode DUT (.core_clk(core_clk), .sys_rst(sys_rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .reqIn(reqIn), .hitOut(hitOut),
        .vecReqIn(vecReqIn), .msgOut(msgOut), .msixModeOut(msixModeOut));
    sbd_host_model host (.core_clk(core_clk), .reqIn(reqIn), .hitOut(hitOut));

    always #2 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            miscompares++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (miscompares == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [11:0] at(logic [11:0] b, int i);
        return b + 12'(4 * i);
    endfunction : at

    function automatic logic [31:0] cfgw(logic en, logic io, logic w64,
                                         logic pf, logic [5:0] sz);
        return {22'h0, sz, pf, w64, io, en};
    endfunction : cfgw

    // Address phase held until hready, then data phase held until hready
    task automatic bus(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge core_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge core_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        bus(1'b1, a, v, d);
    endtask : wr

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, d);
        check(d, e);
    endtask : rdchk

    task automatic stat(input int s, input logic act, input logic err);
        bus(1'b0, STAT_OFS, 32'h0, d);
        check({d[STAT_ACT_LSB + s], d[STAT_ERR_LSB + s]}, {act, err});
    endtask : stat

    task automatic req(input logic io, input logic [63:0] a, input logic hit,
                       input logic [2:0] s, input logic [63:0] o);
        sbd_hit_type h;
        host.issue(io, a, h);
        check({h.valid, h.miss}, {hit, !hit});
        if (hit) begin
            check(h.slot, s);
            check(h.offset, o);
        end
    endtask : req

    task automatic vec(input logic [2:0] v);
        @(posedge core_clk);
        vecReqIn <= '{valid: 1'b1, vec: v};
        @(posedge core_clk);
        vecReqIn <= '{valid: 1'b0, vec: ~v};
        #1 m = msgOut;
    endtask : vec

    initial begin
        core_clk = 0; sys_rst = 1; hsel = 0; haddr = 0; htrans = 0;
        hwrite = 0; hsize = 3'h2; hwdata = 0; vecReqIn = '0;
        miscompares = 0;
        total_checks = 0;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        rdchk(CFG_OFS, CFG_RESET);
        wr(12'h3f0, 32'hffff_ffff);
        rdchk(12'h3f0, 32'h0);
        req(1'b0, 64'h0, 1'b0, 3'h0, 64'h0);
        wr(BASE_OFS, 32'h1000_0000);
        wr(CFG_OFS, cfgw(1, 0, 0, 0, 6'h0c));
        req(1'b0, 64'h1000_0123, 1'b1, 3'h0, 64'h123);
        req(1'b1, 64'h1000_0123, 1'b0, 3'h0, 64'h0);
        req(1'b0, 64'h1000_1000, 1'b0, 3'h0, 64'h0);
        wr(at(BASE_OFS, 1), 32'h2000_0000);
        wr(at(CFG_OFS, 1), cfgw(1, 0, 0, 0, 6'h06));
        stat(1, 1'b0, 1'b1);
        wr(at(CFG_OFS, 1), cfgw(1, 0, 0, 0, 6'h20));
        stat(1, 1'b0, 1'b1);
        wr(at(CFG_OFS, 1), cfgw(1, 0, 0, 0, 6'h07));
        stat(1, 1'b1, 1'b0);
        req(1'b0, 64'h2000_007f, 1'b1, 3'h1, 64'h7f);
        req(1'b0, 64'h2000_0080, 1'b0, 3'h0, 64'h0);
        wr(at(BASE_OFS, 2), 32'h0);
        wr(at(BASE_OFS, 3), 32'h1);
        wr(at(CFG_OFS, 2), cfgw(1, 0, 1, 0, 6'h10));
        wr(at(CFG_OFS, 3), cfgw(1, 0, 0, 0, 6'h07));
        req(1'b0, 64'h1_0000_0005, 1'b1, 3'h2, 64'h5);
        rdchk(at(BASE_OFS, 2), 32'h4);
        stat(3, 1'b0, 1'b0);
        req(1'b0, 64'h40, 1'b0, 3'h0, 64'h0);
        wr(at(CFG_OFS, 5), cfgw(1, 0, 1, 0, 6'h07));
        stat(5, 1'b0, 1'b1);
        wr(at(CFG_OFS, 5), cfgw(1, 0, 0, 1, 6'h07));
        stat(5, 1'b1, 1'b0);
        wr(at(CFG_OFS, 4), cfgw(1, 1, 0, 0, 6'h07));
        stat(4, 1'b0, 1'b1);
        wr(at(CFG_OFS, 4), cfgw(1, 0, 0, 1, 6'h07));
        stat(4, 1'b0, 1'b1);
        wr(CTRL_OFS, 32'h1);
        wr(at(BASE_OFS, 4), 32'h3000);
        wr(at(CFG_OFS, 4), cfgw(1, 1, 0, 0, 6'h04));
        stat(4, 1'b1, 1'b0);
        req(1'b1, 64'h3009, 1'b1, 3'h4, 64'h9);
        req(1'b0, 64'h3009, 1'b0, 3'h0, 64'h0);
        wr(at(CFG_OFS, 1), cfgw(1, 0, 0, 1, 6'h04));
        stat(1, 1'b1, 1'b0);
        wr(CTRL_OFS, 32'h2);
        stat(0, 1'b1, 1'b0);
        stat(4, 1'b0, 1'b1);
        rdchk(CTRL_OFS, 32'h2);
        bus(1'b0, STAT_OFS, 32'h0, d);
        check(d[STAT_SEEN -: 4], 4'hc);
        for (int k = 0; k < 4; k++) begin
            wr(CTRL_OFS, 32'h20 | (k << CTRL_MSIX_LSB));
            #1 check(msixModeOut, k);
            wr(TAB_OFS, 32'hfee0_0000);
            wr(at(TAB_OFS, 2), 32'h55);
            wr(at(TAB_OFS, 3), 32'h0);
            rdchk(at(TAB_OFS, 2), (k == 2) ? 32'h55 : 32'h0);
            vec(3'h0);
            check(m.valid, k == 2);
            if (k == 2) begin
                check(m.addr, 64'hfee0_0000);
                check(m.data, 32'h55);
                check(m.vec, 3'h0);
            end
            vec(3'h1);
            rdchk(PBA_OFS, (k == 2) ? 32'h2 : 32'h0);
        end
        complete_run();
    end
endmodule : tb_top
